// ===== logic/watchdog_pkg.sv
`default_nettype none
package watchdog_pkg;

  // Register byte addresses
  localparam logic [31:0] addr_reload  = 32'hffff0360;
  localparam logic [31:0] addr_count   = 32'hffff0364;
  localparam logic [31:0] addr_control = 32'hffff0368;
  localparam logic [31:0] addr_refresh = 32'hffff036c;

  // Register widths and reset values
  localparam int          count_width     = 16;
  localparam int          control_width   = 9;
  localparam int          lfsr_width      = 8;
  localparam logic [15:0] reload_reset    = 16'h3bf8;
  localparam logic [15:0] count_reset     = 16'h3bf8;
  localparam logic [8:0]  control_reset   = 9'h000;
  localparam logic [7:0]  lfsr_reset      = 8'h00;

  // Control field positions
  localparam int ctl_halt_in_powerdown = 0;
  localparam int ctl_irq_instead       = 1;
  localparam int ctl_prescale_lo       = 2;
  localparam int ctl_prescale_hi       = 3;
  localparam int ctl_secure            = 4;
  localparam int ctl_watchdog          = 5;
  localparam int ctl_periodic          = 6;
  localparam int ctl_enable            = 7;
  localparam int ctl_count_up          = 8;

  // Prescale codes and division limits (terminal count = division - 1)
  localparam logic [1:0] presc_div1   = 2'h0;
  localparam logic [1:0] presc_div16  = 2'h1;
  localparam logic [1:0] presc_div256 = 2'h2;
  localparam logic [7:0] limit_div1   = 8'h00;
  localparam logic [7:0] limit_div16  = 8'h0f;
  localparam logic [7:0] limit_div256 = 8'hff;

  // Galois taps of x^8 + x^6 + x^5 + x + 1
  localparam logic [7:0] lfsr_taps = 8'h63;

  // Counter landmarks
  localparam logic [15:0] count_zero = 16'h0000;
  localparam logic [15:0] count_full = 16'hffff;

  // Length of the core reset request, in sys_clk cycles
  localparam int reset_hold_cycles = 4;

endpackage : watchdog_pkg
`default_nettype wire

// ===== logic/watchdog_timer_secure_refresh.sv
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Control bit 5 enters watchdog operation
// - Watchdog counts down from reload to zero
// - Divide-by-256 and full reload give 512 s
// - Expiry resets core, or interrupts if bit1
// - Refresh write reloads counter, new period
// - Watchdog locks reload and control until power-on
// - Other resets leave configuration and count running
// - Counter halts while debug holds the core
// - Bit 0 halts counter in peripheral power-down
// - Bit 8 selects up, else down
// - Bit 7 enables the counter
// - Bit 6 selects periodic, else free-running
// - Bits 3:2 select the oscillator prescaler
// - Bit 4 enables secure refresh values
// - Expected values from 8-bit LFSR
// - Seed written first, matches advance LFSR
// - Mismatched secure refresh resets immediately
// - Zero seed always forces a reset
// - LFSR state is never readable
// - Seed 0xaa gives 0xaa, 0x37, 0x6e, 0xdc
// - Outside watchdog, refresh write clears interrupt
// - Counter ticks from 32.768 kHz oscillator
module watchdog_timer_secure_refresh #(
  parameter int reset_hold = watchdog_pkg::reset_hold_cycles
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [31:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output var  logic [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        osc_32k,
  input  wire logic        debug_halt,
  input  wire logic        peripheral_powerdown,
  output var  logic        timer_irq,
  output var  logic        core_reset_req
);

  logic [15:0] watchdog_reload;
  logic [15:0] watchdog_count;
  logic [8:0]  watchdog_control;
  logic [7:0]  lfsr;
  logic [7:0]  next_lfsr;
  logic [7:0]  prescale_count;
  logic [7:0]  prescale_limit;
  logic [2:0]  osc_sync;
  logic [1:0]  debug_sync;
  logic        ack;
  logic        bus_write;
  logic        sel_reload;
  logic        sel_count;
  logic        sel_control;
  logic        sel_refresh;
  logic        refresh_write;
  logic        osc_tick;
  logic        halted;
  logic        running;
  logic        count_tick;
  logic        at_terminal;
  logic        terminal_event;
  logic        watchdog_on;
  logic        watchdog_start;
  logic        secure_on;
  logic        refresh_match;
  logic        refresh_reload;
  logic        refresh_fault;
  logic        expiry_reset;
  logic        expiry_irq;
  logic        reset_event;
  logic [7:0]  reset_timer;

  assign watchdog_on = watchdog_control[watchdog_pkg::ctl_watchdog];
  assign secure_on   = watchdog_on && watchdog_control[watchdog_pkg::ctl_secure];
  // entry into watchdog loads the reload value
  assign watchdog_start = bus_write && sel_control && !watchdog_on && byteenable[0] && writedata[watchdog_pkg::ctl_watchdog];

  // Bus decode
  assign sel_reload  = (address == watchdog_pkg::addr_reload);
  assign sel_count   = (address == watchdog_pkg::addr_count);
  assign sel_control = (address == watchdog_pkg::addr_control);
  assign sel_refresh = (address == watchdog_pkg::addr_refresh);

  // Every access is answered one cycle after it is presented
  assign waitrequest   = (read || write) && !ack;
  assign bus_write     = write && ack;
  assign refresh_write = bus_write && sel_refresh;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ack <= 1'b0;
    end
    else
    begin
      ack <= (read || write) && !ack;
    end
  end

  // Read data; unmapped and write-only addresses read as zero
  // refresh reads zero
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      readdata <= 32'h0000_0000;
    end
    else if (read && !ack)
    begin
      readdata <= 32'h0000_0000;
      if (sel_reload)
      begin
        readdata[15:0] <= watchdog_reload;
      end
      else if (sel_count)
      begin
        readdata[15:0] <= watchdog_count;
      end
      else if (sel_control)
      begin
        readdata[8:0] <= watchdog_control;
      end
    end
  end

  // Reload register
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      watchdog_reload <= watchdog_pkg::reload_reset;
    end
    else if (bus_write && sel_reload && !watchdog_on)
    begin
      if (byteenable[0])
      begin
        watchdog_reload[7:0] <= writedata[7:0];
      end
      if (byteenable[1])
      begin
        watchdog_reload[15:8] <= writedata[15:8];
      end
    end
  end

  // Control register; only the power-on reset clears the lock
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      watchdog_control <= watchdog_pkg::control_reset;
    end
    else if (bus_write && sel_control && !watchdog_on)
    begin
      if (byteenable[0])
      begin
        watchdog_control[7:0] <= writedata[7:0];
      end
      if (byteenable[1])
      begin
        watchdog_control[8] <= writedata[8];
      end
    end
  end

  // Oscillator pin synchroniser; stage 0 feeds only stage 1
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      osc_sync <= 3'h0;
    end
    else
    begin
      osc_sync <= {osc_sync[1:0], osc_32k};
    end
  end

  assign osc_tick = osc_sync[1] && !osc_sync[2];

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      debug_sync <= 2'h0;
    end
    else
    begin
      debug_sync <= {debug_sync[0], debug_halt};
    end
  end

  assign halted = debug_sync[1] ||
                  (peripheral_powerdown && watchdog_control[watchdog_pkg::ctl_halt_in_powerdown]);

  assign running = !halted && (watchdog_on || watchdog_control[watchdog_pkg::ctl_enable]);

  always_comb
  begin
    unique case (watchdog_control[watchdog_pkg::ctl_prescale_hi:watchdog_pkg::ctl_prescale_lo])
      watchdog_pkg::presc_div16:  prescale_limit = watchdog_pkg::limit_div16;
      watchdog_pkg::presc_div256: prescale_limit = watchdog_pkg::limit_div256;
      default:                    prescale_limit = watchdog_pkg::limit_div1;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      prescale_count <= 8'h00;
    end
    else if (!running)
    begin
      prescale_count <= prescale_count;
    end
    else if (osc_tick)
    begin
      if (prescale_count >= prescale_limit)
      begin
        prescale_count <= 8'h00;
      end
      else
      begin
        prescale_count <= prescale_count + 8'h01;
      end
    end
  end

  assign count_tick = running && osc_tick && (prescale_count >= prescale_limit);

  // terminal value depends on direction; watchdog always down
  assign at_terminal = (watchdog_control[watchdog_pkg::ctl_count_up] && !watchdog_on) ?
                       (watchdog_count == watchdog_pkg::count_full) :
                       (watchdog_count == watchdog_pkg::count_zero);
  assign terminal_event = count_tick && at_terminal;

  assign expiry_reset = terminal_event && watchdog_on && !watchdog_control[watchdog_pkg::ctl_irq_instead];
  assign expiry_irq   = terminal_event && (!watchdog_on || watchdog_control[watchdog_pkg::ctl_irq_instead]);

  // Galois step of the expected-value register
  assign next_lfsr = {lfsr[6:0], 1'b0} ^ (lfsr[7] ? watchdog_pkg::lfsr_taps : 8'h00);

  assign refresh_match = (lfsr != watchdog_pkg::lfsr_reset) && (writedata[7:0] == lfsr);

  assign refresh_reload = refresh_write && (!secure_on || refresh_match);
  assign refresh_fault  = refresh_write && secure_on && !refresh_match;

  // Counter; untouched by the core reset it requests
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      watchdog_count <= watchdog_pkg::count_reset;
    end
    else if (refresh_reload || watchdog_start)
    begin
      watchdog_count <= watchdog_reload;
    end
    else if (count_tick)
    begin
      if (at_terminal && (watchdog_on || watchdog_control[watchdog_pkg::ctl_periodic]))
      begin
        watchdog_count <= watchdog_reload;
      end
      else if (watchdog_control[watchdog_pkg::ctl_count_up] && !watchdog_on)
      begin
        watchdog_count <= watchdog_count + 16'h0001;
      end
      else
      begin
        watchdog_count <= watchdog_count - 16'h0001;
      end
    end
  end

  // Expected refresh value
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      lfsr <= watchdog_pkg::lfsr_reset;
    end
    else if (refresh_write && !watchdog_on)
    begin
      lfsr <= writedata[7:0];
    end
    else if (refresh_reload && secure_on)
    begin
      lfsr <= next_lfsr;
    end
  end

  // Pending interrupt; a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      timer_irq <= 1'b0;
    end
    else if (expiry_irq)
    begin
      timer_irq <= 1'b1;
    end
    else if (refresh_write && !watchdog_on)
    begin
      timer_irq <= 1'b0;
    end
  end

  assign reset_event = expiry_reset || refresh_fault;

  // Core reset request, stretched to a fixed length
  // configuration and counter are not reset by it
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      reset_timer <= 8'h00;
    end
    else if (reset_event)
    begin
      reset_timer <= 8'(reset_hold);
    end
    else if (reset_timer != 8'h00)
    begin
      reset_timer <= reset_timer - 8'h01;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      core_reset_req <= 1'b0;
    end
    else
    begin
      core_reset_req <= reset_event || (reset_timer > 8'h01);
    end
  end

endmodule : watchdog_timer_secure_refresh
`default_nettype wire

// ===== testbench/watchdog_properties.sv
`timescale 1ns/100ps
`default_nettype none
module watchdog_properties #(
  parameter int reset_hold = 4
) (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [31:0] address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        osc_32k,
  input wire logic        debug_halt,
  input wire logic        peripheral_powerdown,
  input wire logic        timer_irq,
  input wire logic        core_reset_req
);
  logic [8:0] ctl;
  int         hcnt;
  wire logic  take = (read | write) & ~waitrequest;
  wire logic  ref_take = take & write & (address == watchdog_pkg::addr_refresh);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Mirror of control, frozen once watchdog mode is on
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ctl <= 9'h000;
    else if (take && write && address == watchdog_pkg::addr_control && !ctl[5])
      ctl <= writedata[8:0];
  end
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      hcnt <= 0;
    else
      hcnt <= core_reset_req ? hcnt + 1 : 0;
  end
  sequence s_req_start;
    $rose(read | write);
  endsequence
  sequence s_zero_refresh;
    ref_take && ctl[5] && ctl[4] && writedata[7:0] == 8'h00;
  endsequence
  a_bus_wait: assert property (s_req_start |-> waitrequest ##1 !waitrequest)
    else $error("bus answer not after one wait cycle");
  a_zero_seed: assert property (s_zero_refresh |-> ##[1:3] core_reset_req)
    else $error("zero refresh gave no reset");
  a_reset_len: assert property (core_reset_req |-> hcnt < reset_hold)
    else $error("reset request too long");
  a_reset_full: assert property ($fell(core_reset_req) |-> hcnt == reset_hold)
    else $error("reset request too short");
  a_irq_source: assert property ($rose(timer_irq) |-> ctl[1] || !ctl[5])
    else $error("interrupt while reset selected");
  a_irq_clear: assert property ($fell(timer_irq) |-> $past(ref_take && !ctl[5]))
    else $error("interrupt cleared without refresh");
  a_refresh_read: assert property (take && read && address == watchdog_pkg::addr_refresh |-> readdata == 32'h0)
    else $error("refresh register readable");
  a_ctl_lock: assert property (take && read && address == watchdog_pkg::addr_control |-> readdata == {23'h0, ctl})
    else $error("control readback wrong");
endmodule : watchdog_properties
bind watchdog_timer_secure_refresh watchdog_properties #(.reset_hold(reset_hold)) i_watchdog_properties (
  .sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .osc_32k(osc_32k),
  .debug_halt(debug_halt), .peripheral_powerdown(peripheral_powerdown), .timer_irq(timer_irq),
  .core_reset_req(core_reset_req));
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [31:0] adr_ld  = watchdog_pkg::addr_reload;
  localparam logic [31:0] adr_cnt = watchdog_pkg::addr_count;
  localparam logic [31:0] adr_ctl = watchdog_pkg::addr_control;
  localparam logic [31:0] adr_ref = watchdog_pkg::addr_refresh;
  logic        sys_clk, rst, read, write, debug_halt, peripheral_powerdown;
  logic [31:0] address, writedata, readdata, q;
  logic        waitrequest, timer_irq, core_reset_req;
  logic [2:0]  oc;
  logic [7:0]  lfsr, sv;
  int          err_count, num_checks, seed, m_reload, i, n_ok;
  watchdog_timer_secure_refresh #(.reset_hold(2)) i_watchdog_timer_secure_refresh (
    .sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
    .osc_32k(oc[2]), .debug_halt(debug_halt), .peripheral_powerdown(peripheral_powerdown),
    .timer_irq(timer_irq), .core_reset_req(core_reset_req));
  always #20 sys_clk = ~sys_clk;
  // Oscillator sped up to one tick per 8 cycles to keep the run short
  always @(posedge sys_clk) oc <= oc + 3'h1;
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic bus(input logic wr, input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge sys_clk);
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= !wr;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0)
    begin
      err_count++;
      conclude();
    end
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic rd(input string nm, input logic [31:0] a, exp);
    bus(1'b0, a, 32'h0);
    chk(nm, q, exp);
  endtask : rd
  task automatic wait_hi(input bit rq, input bit exp, input int lim);
    logic s;
    s = 1'b0;
    repeat (lim)
    begin
      @(posedge sys_clk);
      s = s | (rq ? core_reset_req : timer_irq);
    end
    chk(rq ? "core_reset_req" : "timer_irq", s, exp);
    if (exp && s !== 1'b1)
      conclude();
  endtask : wait_hi
  // Count step over 40 cycles: 0 held, 1 down, 2 up
  task automatic still(input int mode);
    logic [31:0] a0;
    bus(1'b0, adr_cnt, 32'h0);
    a0 = q;
    repeat (40) @(posedge sys_clk);
    bus(1'b0, adr_cnt, 32'h0);
    chk("count step", mode == 0 ? q == a0 : mode == 1 ? q < a0 : q > a0, 1);
  endtask : still
  task automatic por;
    rst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
  endtask : por
  initial
  begin
    sys_clk = 0; read = 0; write = 0; address = 0; writedata = 0; oc = 0;
    debug_halt = 0; peripheral_powerdown = 0; err_count = 0; num_checks = 0; seed = 61;
    por();
    rd("reload", adr_ld, 32'h3bf8);
    rd("count", adr_cnt, 32'h3bf8);
    rd("control", adr_ctl, 32'h0);
    rd("unmapped", 32'hffff0370, 32'h0);
    rd("refresh", adr_ref, 32'h0);
    m_reload = $random(seed) & 32'hffff;
    bus(1'b1, adr_ld, m_reload);
    rd("reload", adr_ld, m_reload);
    $display("test 1 done");
    bus(1'b1, adr_ld, 32'h3);
    bus(1'b1, adr_ref, 32'h0);
    bus(1'b1, adr_ctl, 32'hc0);
    wait_hi(0, 1, 300);
    bus(1'b1, adr_ld, 32'h100);
    // Let a periodic reload take the long value so no event meets the clear
    repeat (40) @(posedge sys_clk);
    bus(1'b1, adr_ref, 32'h0);
    @(posedge sys_clk);
    chk("irq cleared", timer_irq, 1'b0);
    debug_halt <= 1'b1;
    // Cover the synchroniser delay before the first sample
    repeat (4) @(posedge sys_clk);
    still(0);
    debug_halt <= 1'b0;
    still(1);
    peripheral_powerdown <= 1'b1;
    still(1);
    bus(1'b1, adr_ctl, 32'hc1);
    still(0);
    peripheral_powerdown <= 1'b0;
    bus(1'b1, adr_ctl, 32'h40);
    still(0);
    bus(1'b1, adr_ctl, 32'h180);
    still(2);
    bus(1'b1, adr_ctl, 32'h188);
    still(0);
    $display("test 2 done");
    por();
    bus(1'b1, adr_ld, 32'h2);
    bus(1'b1, adr_ctl, 32'h22);
    wait_hi(0, 1, 200);
    bus(1'b1, adr_ld, 32'h1234);
    bus(1'b1, adr_ctl, 32'h0);
    rd("reload locked", adr_ld, 32'h2);
    rd("control locked", adr_ctl, 32'h22);
    $display("test 3 done");
    por();
    bus(1'b1, adr_ld, 32'h14); // timeout scaled to the fast oscillator
    bus(1'b1, adr_ctl, 32'h20);
    repeat (4)
    begin
      wait_hi(1, 0, 60);
      bus(1'b1, adr_ref, 32'h0);
    end
    wait_hi(1, 1, 400);
    rd("control kept", adr_ctl, 32'h20);
    still(1);
    $display("test 4 done");
    for (int k = 0; k < 3; k++)
    begin
      por();
      lfsr = k == 0 ? 8'haa : k == 1 ? 8'($random(seed)) | 8'h01 : 8'h00;
      n_ok = lfsr == 8'h00 ? 0 : 3;
      bus(1'b1, adr_ld, 32'hffff);
      bus(1'b1, adr_ref, {24'h0, lfsr});
      bus(1'b1, adr_ctl, 32'h30);
      for (i = 0; i <= n_ok; i++)
      begin
        sv = i < n_ok ? lfsr : k == 0 ? 8'h66 : lfsr ^ {7'h0, lfsr != 8'h00};
        bus(1'b1, adr_ref, {24'h0, sv});
        wait_hi(1, i == n_ok, 12);
        lfsr = {lfsr[6:0], 1'b0} ^ (lfsr[7] ? 8'h63 : 8'h00);
      end
    end
    $display("test 5 done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
